// ### src/modem_status_regs.sv
// modem status, bank select, scratch, divisor latches and level counter read-out
// assumes the modem pins are asynchronous and the FIFO levels come from the same clock
`include "modem_status_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module modem_status_regs
    import modem_status_pkg::*;
(
    input  wire logic                i_clk,
    input  wire logic                i_arst_n,
    input  wire logic [`ADDR_W-1:0]  i_addr,
    input  wire logic [7:0]          i_wdata,
    input  wire logic                i_wr,
    input  wire logic                i_rd,
    input  wire logic                i_cd_n,
    input  wire logic                i_ri_n,
    input  wire logic                i_dsr_n,
    input  wire logic                i_cts_n,
    input  wire logic [7:0]          i_modem_control_reg,
    input  wire logic [7:0]          i_tx_free_space_count,
    input  wire logic [7:0]          i_rx_fill_count,
    output logic [7:0]               o_rdata,
    output logic [15:0]              o_divisor,
    output logic [1:0]               o_bank,
    output logic                     o_level_read_en,
    output logic                     o_modem_irq_req,
    output logic                     o_irq
);

    state_t q;
    state_t d;

    // bit order of the change vector matches status bits 3..0: cd, ri, dsr, cts
    function automatic logic [7:0] status_byte(input logic [3:0] pins_n,
                                               input logic [3:0] delta,
                                               input logic [7:0] modem_control_reg);
        logic [3:0] lvl;
        lvl = 4'h0;
        if (modem_control_reg[`CTL_LOOP_BIT]) begin
            lvl = {modem_control_reg[3], modem_control_reg[2], modem_control_reg[0], modem_control_reg[1]};
        end else begin
            lvl = ~pins_n;
        end
        status_byte = {lvl, delta};
    endfunction

    logic [3:0] edges;
    logic       status_rd;
    logic       lvl_ok;
    logic [1:0] evt;

    always_comb begin
        d         = q;
        // two stages before any use; sync1 feeds only sync2
        d.sync1   = {i_cd_n, i_ri_n, i_dsr_n, i_cts_n};
        d.sync2   = q.sync1;
        d.prev    = q.sync2;
        edges     = q.sync2 ^ q.prev;
        // ring change counts only when the pin itself goes from 0 to 1
        edges[2]  = ~q.prev[2] & q.sync2[2];
        status_rd = i_rd && (i_addr == `OFS_STATUS_SELECT);
        // set wins over clear-on-read so a coincident edge survives
        d.delta   = (status_rd ? 4'h0 : q.delta) | edges;
        d.msi     = |d.delta;
        lvl_ok    = (q.bank_sel[`SEL_HI:`SEL_LO] == `SEL_GENERAL)
                    && q.bank_sel[`LVL_EN_BIT];

        evt       = {q.msi == 1'b0 && d.msi, |edges};
        d.irq_stat = q.irq_stat | evt;

        if (i_wr) begin
            case (i_addr)
                `OFS_STATUS_SELECT: d.bank_sel = {5'h00, i_wdata[2:0]};
                `OFS_SCRATCH:       d.scratch  = i_wdata;
                `OFS_DIV_LOW:       d.div_low  = i_wdata;
                `OFS_DIV_HIGH:      d.div_high = i_wdata;
                `OFS_IRQ_STATUS:    d.irq_stat = (q.irq_stat & ~i_wdata[1:0]) | evt;
                `OFS_IRQ_MASK:      d.irq_mask = i_wdata[1:0];
                default: ;
            endcase
        end

        d.rdata = `UNMAPPED_READ;
        if (i_rd) begin
            case (i_addr)
                `OFS_STATUS_SELECT: d.rdata = status_byte(q.sync2, q.delta,
                                                          i_modem_control_reg);
                `OFS_SCRATCH:       d.rdata = q.scratch;
                `OFS_DIV_LOW:       d.rdata = q.div_low;
                `OFS_DIV_HIGH:      d.rdata = q.div_high;
                `OFS_TX_FREE:       d.rdata = lvl_ok ? i_tx_free_space_count
                                                     : `UNMAPPED_READ;
                `OFS_RX_FILL:       d.rdata = lvl_ok ? i_rx_fill_count
                                                     : `UNMAPPED_READ;
                `OFS_IRQ_STATUS:    d.rdata = {6'h00, q.irq_stat};
                `OFS_IRQ_MASK:      d.rdata = {6'h00, q.irq_mask};
                default:            d.rdata = `UNMAPPED_READ;
            endcase
        end
        d.irq = |(d.irq_stat & d.irq_mask);
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            q          <= '0;
            q.sync1    <= `RST_INPUTS;
            q.sync2    <= `RST_INPUTS;
            q.prev     <= `RST_INPUTS;
        end else begin
            q <= d;
        end
    end

    assign o_rdata         = q.rdata;
    assign o_divisor       = {q.div_high, q.div_low};
    assign o_bank          = q.bank_sel[`SEL_HI:`SEL_LO];
    assign o_level_read_en = q.bank_sel[`LVL_EN_BIT];
    assign o_modem_irq_req = q.msi;
    assign o_irq           = q.irq;

endmodule

`default_nettype wire

// ### src/modem_status_defines.svh
// register offsets, field positions and reset values for the modem status / bank select block
// assumes a plain byte-wide register port with one-cycle read latency
// How it works
// - status register is read-only; writes at its address go to bank-select register.
// - bits 3,1,0 flag a change of carrier-detect, data-set-ready, clear-to-send since last read.
// - bit 2 flags only a ring-indicator rise from 0 to 1.
// - change bits clear on status read and are 0 when nothing changed.
// - any of status bits 3:0 set raises the modem-status interrupt request.
// - bit 7 is inverted carrier-detect, or control bit 3 in loopback.
// - bit 6 is inverted ring-indicator, or control bit 2 in loopback.
// - bit 5 is inverted data-set-ready, or control bit 0 in loopback.
// - bit 4 is inverted clear-to-send, or control bit 1 in loopback.
// - bank-select register is write-only; bits 7:3 are reserved.
// - select field 00 general, 01 first extra, 10 second extra, 11 reserved.
// - bank-select bit 0 set makes the FIFO level counters readable.
// - level counters are reachable only while the select field is 00.
// - scratch register stores 8 bits and returns them, no side effect.
// - two byte latches form the 16-bit divisor, high byte most significant.
// - transmit level counter reads free entries in the transmit FIFO.
// - receive level counter reads characters held in the receive FIFO.
`ifndef MODEM_STATUS_DEFINES_SVH
`define MODEM_STATUS_DEFINES_SVH

`define ADDR_W             4
`define OFS_STATUS_SELECT  4'h0
`define OFS_SCRATCH        4'h1
`define OFS_DIV_LOW        4'h2
`define OFS_DIV_HIGH       4'h3
`define OFS_TX_FREE        4'h4
`define OFS_RX_FILL        4'h5
`define OFS_IRQ_STATUS     4'h6
`define OFS_IRQ_MASK       4'h7

`define SEL_LO             1
`define SEL_HI             2
`define SEL_GENERAL        2'h0
`define LVL_EN_BIT         0
`define CTL_LOOP_BIT       4

`define RST_BYTE           8'h00
`define RST_INPUTS         4'hf
`define UNMAPPED_READ      8'h00

`endif

// ### src/modem_status_pkg.sv
// types shared by the modem status / bank select block
// constants live in modem_status_defines.svh
package modem_status_pkg;

    typedef enum logic [1:0] {
        BANK_GENERAL = 2'b00,
        BANK_EXTRA1  = 2'b01,
        BANK_EXTRA2  = 2'b10,
        BANK_RSVD    = 2'b11
    } bank_t;

    // modem inputs in order cd, ri, dsr, cts (active low pins)
    typedef struct packed {
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] prev;
        logic [3:0] delta;
        logic [7:0] bank_sel;
        logic [7:0] scratch;
        logic [7:0] div_low;
        logic [7:0] div_high;
        logic [7:0] rdata;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic       irq;
        logic       msi;
    } state_t;

endpackage

// ### testbench/modem_pins_model.sv
// far-side modem: drives the four active-low status pins
// assumes the bench commands the levels; pins move off the clock edge
`timescale 1ns/100ps
`default_nettype none
module modem_pins_model (
    input  wire logic [3:0] i_level_n,
    output logic            o_cd_n,
    output logic            o_ri_n,
    output logic            o_dsr_n,
    output logic            o_cts_n
);
    // skew keeps pin edges unrelated to the device clock
    assign #3 {o_cd_n, o_ri_n, o_dsr_n, o_cts_n} = i_level_n;
endmodule
`default_nettype wire

// ### testbench/modem_status_regs_assertions.sv
// checker for the modem status / bank select register block
// sees only the top ports; bench must not read status within 8 cycles of a pin edge
`include "modem_status_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module modem_status_regs_chk (
    input wire logic i_clk, i_arst_n, i_wr, i_rd, i_cts_n,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata, i_modem_control_reg, i_tx_free_space_count, o_rdata,
    input wire logic [15:0] o_divisor,
    input wire logic [1:0] o_bank,
    input wire logic o_level_read_en, o_modem_irq_req, o_irq
);
    logic [7:0] wd_q, mcr_q;
    always_ff @(posedge i_clk) begin
        wd_q <= i_wdata;
        mcr_q <= i_modem_control_reg;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    rdata_idle_a: assert property (!i_rd |=> o_rdata == 8'h00) else $error("read data not idle");
    bank_write_a: assert property (i_wr && i_addr == `OFS_STATUS_SELECT |=> o_bank == wd_q[2:1] && o_level_read_en == wd_q[0]) else $error("bank select not taken");
    level_gate_a: assert property (i_rd && i_addr == `OFS_TX_FREE |=> o_rdata == (($past(o_bank) == 2'h0 && $past(o_level_read_en)) ? $past(i_tx_free_space_count) : 8'h00)) else $error("tx level gating wrong");
    loop_mirror_a: assert property (i_rd && i_addr == `OFS_STATUS_SELECT && i_modem_control_reg[4] |=> o_rdata[7:4] == {mcr_q[3], mcr_q[2], mcr_q[0], mcr_q[1]}) else $error("loopback mirror wrong");
    div_high_a: assert property (i_wr && i_addr == `OFS_DIV_HIGH |=> o_divisor[15:8] == wd_q) else $error("divisor high wrong");
    div_low_a: assert property (i_wr && i_addr == `OFS_DIV_LOW |=> o_divisor[7:0] == wd_q) else $error("divisor low wrong");
    scratch_quiet_a: assert property (i_wr && i_addr == `OFS_SCRATCH |=> $stable(o_divisor) && $stable(o_bank)) else $error("scratch write leaked");
    cts_change_a: assert property ($fell(i_cts_n) |-> ##[2:6] o_modem_irq_req) else $error("cts change missed");
    cover property (i_rd && i_addr == `OFS_STATUS_SELECT && i_modem_control_reg[4]);
    cover property (o_irq);
    cover property (i_rd && i_addr == `OFS_TX_FREE && o_level_read_en && o_bank == 2'h0);
endmodule
bind modem_status_regs modem_status_regs_chk u_chk (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_wr(i_wr), .i_rd(i_rd), .i_cts_n(i_cts_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_modem_control_reg(i_modem_control_reg), .i_tx_free_space_count(i_tx_free_space_count),
    .o_rdata(o_rdata), .o_divisor(o_divisor), .o_bank(o_bank), .o_level_read_en(o_level_read_en),
    .o_modem_irq_req(o_modem_irq_req), .o_irq(o_irq));
`default_nettype wire

// ### testbench/tb_modem_status_and_bank_select_regs.sv
// bench for the modem status / bank select register block
// assumes one-cycle read latency and the register map of the defines header
`include "modem_status_defines.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_modem_status_and_bank_select_regs import modem_status_pkg::*;;
    logic clk = 0, arst_n = 0, wr = 0, rd = 0;
    logic [3:0] addr = 0, pins_n = 4'hf;
    logic [7:0] wdata = 0, modem_control_reg = 0, txc = 8'h40, rxc = 8'h21, rdata, got;
    logic [15:0] div;
    logic [1:0] bank;
    logic lvl_en, mreq, irq, cd_n, ri_n, dsr_n, cts_n;
    int error_cnt = 0, check_count = 0, i;
    modem_pins_model peer (.i_level_n(pins_n), .o_cd_n(cd_n), .o_ri_n(ri_n), .o_dsr_n(dsr_n), .o_cts_n(cts_n));
    modem_status_regs dut (.i_clk(clk), .i_arst_n(arst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .i_cd_n(cd_n), .i_ri_n(ri_n), .i_dsr_n(dsr_n), .i_cts_n(cts_n),
        .i_modem_control_reg(modem_control_reg), .i_tx_free_space_count(txc), .i_rx_fill_count(rxc),
        .o_rdata(rdata), .o_divisor(div), .o_bank(bank), .o_level_read_en(lvl_en),
        .o_modem_irq_req(mreq), .o_irq(irq));
    initial forever #12.5 clk = ~clk;
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge clk) wr <= 1'b0;
        #1;
    endtask
    // data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk) {addr, rd} <= {a, 1'b1};
        @(posedge clk) rd <= 1'b0;
        #1 got = rdata;
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #100us error_cnt++;
        end_sim();
    end
    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        rd_reg(`OFS_STATUS_SELECT); `CHK("idle status", 8'h00, got)
        wr_reg(`OFS_DIV_LOW, 8'h34); wr_reg(`OFS_DIV_HIGH, 8'h12); `CHK("divisor", 16'h1234, div)
        wr_reg(`OFS_SCRATCH, 8'h5a); rd_reg(`OFS_SCRATCH); `CHK("scratch", 8'h5a, got)
        rd_reg(`OFS_DIV_HIGH); `CHK("div high", 8'h12, got)
        rd_reg(4'h8); `CHK("unmapped", 8'h00, got)
        $display("registers test done");
        for (i = 0; i < 4; i++) begin
            @(posedge clk) pins_n[i] <= 1'b0;
            repeat (8) @(posedge clk);
            `CHK("change irq", (i == 2) ? 1'b0 : 1'b1, mreq)
            rd_reg(`OFS_STATUS_SELECT); `CHK("status fall", {~pins_n, (i == 2) ? 4'h0 : 4'h1 << i}, got)
            rd_reg(`OFS_STATUS_SELECT); `CHK("status clear", {~pins_n, 4'h0}, got)
            repeat (2) @(posedge clk);
            `CHK("irq cleared", 1'b0, mreq)
            @(posedge clk) pins_n[i] <= 1'b1;
            repeat (8) @(posedge clk);
            rd_reg(`OFS_STATUS_SELECT); `CHK("status rise", {4'h0, 4'h1 << i}, got)
        end
        `CHK("masked irq", 1'b0, irq)
        wr_reg(`OFS_IRQ_MASK, 8'h01); repeat (2) @(posedge clk); `CHK("irq on", 1'b1, irq)
        wr_reg(`OFS_IRQ_STATUS, 8'h03); repeat (2) @(posedge clk); `CHK("irq off", 1'b0, irq)
        wr_reg(`OFS_IRQ_MASK, 8'h00);
        $display("modem change test done");
        for (i = 0; i < 8; i++) begin
            wr_reg(`OFS_STATUS_SELECT, 8'hf8 | 8'(i)); `CHK("bank", 3'(i), {bank, lvl_en})
            rd_reg(`OFS_TX_FREE); `CHK("tx free", (i == 1) ? txc : 8'h00, got)
            rd_reg(`OFS_RX_FILL); `CHK("rx fill", (i == 1) ? rxc : 8'h00, got)
        end
        $display("bank select test done");
        @(posedge clk) modem_control_reg <= 8'h1a;
        rd_reg(`OFS_STATUS_SELECT); `CHK("loop a", 4'h9, got[7:4])
        @(posedge clk) modem_control_reg <= 8'h15;
        rd_reg(`OFS_STATUS_SELECT); `CHK("loop b", 4'h6, got[7:4])
        $display("loopback test done");
        end_sim();
    end
endmodule
`default_nettype wire
